// >>> testbench/cei_evaluator_assertions.sv
// checker for the evaluator's hart lines and register reads
// assumes binding to cei_evaluator; sees only its ports
`include "cei_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cei_evaluator_checker
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // watched inputs
  input wire logic mm_rd_i,
  input wire logic [`CEI_MM_ADDR_W-1:0] mm_addr_i,
  input wire logic csr_rd_i,
  input wire logic [`CEI_CSR_ADDR_W-1:0] csr_addr_i,
  input wire logic mstatus_mie_i,
  input wire logic mie_meie_i,
  input wire logic irq_taken_i,
  // watched outputs
  input wire logic [31:0] mm_rdata_o,
  input wire logic [31:0] csr_rdata_o,
  input wire logic ext_irq_o,
  input wire logic mip_meip_o,
  input wire logic wake_notice_o,
  input wire logic sleep_exit_o,
  input wire logic clear_mstatus_mie_o,
  input wire logic [31:0] vector_fetch_addr_o
);
  // one domain: shared clock and reset
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_meip_mirror;
    mip_meip_o == ext_irq_o;
  endproperty
  a_meip_mirror: assert property (p_meip_mirror) else $error("meip differs from irq");
  property p_sleep_cause;
    sleep_exit_o |-> $past(mstatus_mie_i) && $past(mie_meie_i);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep exit without enables");
  property p_clear_follow;
    irq_taken_i && ext_irq_o |=> clear_mstatus_mie_o;
  endproperty
  a_clear_follow: assert property (p_clear_follow) else $error("no enable clear pulse");
  property p_clear_cause;
    clear_mstatus_mie_o |-> $past(irq_taken_i) && $past(ext_irq_o);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("stray enable clear");
  property p_irq_winner;
    ext_irq_o |-> vector_fetch_addr_o[9:2] != 8'h00;
  endproperty
  a_irq_winner: assert property (p_irq_winner) else $error("irq with no winner");
  property p_wake_winner;
    wake_notice_o |-> vector_fetch_addr_o[9:2] != 8'h00;
  endproperty
  a_wake_winner: assert property (p_wake_winner) else $error("wake with no winner");
  property p_vector_word;
    vector_fetch_addr_o[1:0] == 2'b00;
  endproperty
  a_vector_word: assert property (p_vector_word) else $error("fetch address unaligned");
  property p_ptr_read;
    csr_rd_i && csr_addr_i == `CEI_CSR_HANDLER |=> csr_rdata_o[1:0] == 2'b00;
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer low bits set");
  property p_src0_read;
    mm_rd_i && mm_addr_i == 15'h0000 |=> mm_rdata_o == 32'h00000000;
  endproperty
  a_src0_read: assert property (p_src0_read) else $error("source zero reads nonzero");
  property p_reset_quiet;
    $fell(reset_i) |-> !ext_irq_o && !wake_notice_o && !sleep_exit_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("lines active after reset");

  // main scenarios reached
  c_irq: cover property ($rose(ext_irq_o));
  c_wake: cover property (wake_notice_o && sleep_exit_o);
  c_clear: cover property (clear_mstatus_mie_o);
endmodule // cei_evaluator_checker

bind cei_evaluator cei_evaluator_checker u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .mm_rd_i(mm_rd_i), .mm_addr_i(mm_addr_i), .csr_rd_i(csr_rd_i), .csr_addr_i(csr_addr_i),
  .mstatus_mie_i(mstatus_mie_i), .mie_meie_i(mie_meie_i), .irq_taken_i(irq_taken_i),
  .mm_rdata_o(mm_rdata_o), .csr_rdata_o(csr_rdata_o), .ext_irq_o(ext_irq_o),
  .mip_meip_o(mip_meip_o), .wake_notice_o(wake_notice_o), .sleep_exit_o(sleep_exit_o),
  .clear_mstatus_mie_o(clear_mstatus_mie_o), .vector_fetch_addr_o(vector_fetch_addr_o));
`default_nettype wire

// >>> testbench/cei_evaluator_tb.sv
// self-checking bench for the evaluator with the far side model
// assumes the checker is bound from its own file
`include "cei_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cei_evaluator_tb;
  import cei_pkg::*;
  // one table row: priorities, thresholds, expected results
  typedef struct packed {logic [3:0] pa, pb, thr, cur; logic [7:0] id; logic [3:0] cp;
    logic irq, wake;} cei_row_t;
  localparam logic [31:0] VT = 32'habcde400;
  cei_row_t rows [7] = '{'{4'h5, 4'h5, 4'h0, 4'h0, 8'h03, 4'h5, 1'b1, 1'b0},
    '{4'h4, 4'h9, 4'h0, 4'h0, 8'h05, 4'h9, 1'b1, 1'b0},
    '{4'h9, 4'h9, 4'h9, 4'h0, 8'h03, 4'h9, 1'b0, 1'b0},
    '{4'hf, 4'h2, 4'h0, 4'he, 8'h03, 4'hf, 1'b1, 1'b1},
    '{4'h2, 4'hf, 4'hf, 4'h0, 8'h05, 4'hf, 1'b0, 1'b1},
    '{4'h7, 4'h3, 4'h0, 4'h7, 8'h03, 4'h7, 1'b0, 1'b0},
    '{4'h0, 4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 1'b0, 1'b0}};
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic mm_wr = 1'b0, mm_rd = 1'b0, csr_wr = 1'b0, csr_rd = 1'b0;
  logic [14:0] mm_addr = '0;
  logic [2:0] csr_addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] mm_rdata, csr_rdata, vfa, rd;
  logic [255:0] src_req;
  logic ext_irq, meip, wake, sleep_x, clr_mie, mst_mie, meie, taken;
  logic saw_clear = 1'b0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  cei_evaluator dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .src_req_i(src_req),
    .mm_wr_i(mm_wr), .mm_rd_i(mm_rd), .mm_addr_i(mm_addr), .mm_wdata_i(wdata),
    .mm_rdata_o(mm_rdata), .csr_wr_i(csr_wr), .csr_rd_i(csr_rd), .csr_addr_i(csr_addr),
    .csr_wdata_i(wdata), .csr_rdata_o(csr_rdata), .mstatus_mie_i(mst_mie),
    .mie_meie_i(meie), .irq_taken_i(taken), .ext_irq_o(ext_irq), .mip_meip_o(meip),
    .wake_notice_o(wake), .sleep_exit_o(sleep_x), .clear_mstatus_mie_o(clr_mie),
    .vector_fetch_addr_o(vfa));
  cei_far_side_model u_far (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ext_irq_i(ext_irq),
    .clear_mstatus_mie_i(clr_mie), .src_req_o(src_req), .mstatus_mie_o(mst_mie),
    .mie_meie_o(meie), .irq_taken_o(taken));

  // 100 MHz clock
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one strobe cycle on either port; read data lands in rd
  task automatic bus(input logic csr, input logic wr, input logic [14:0] a,
    input logic [31:0] d);
    @(negedge sys_clk_i);
    if (csr)
      {csr_wr, csr_rd} = {wr, !wr};
    else
      {mm_wr, mm_rd} = {wr, !wr};
    mm_addr = a;
    csr_addr = a[2:0];
    wdata = d;
    @(negedge sys_clk_i);
    {mm_wr, mm_rd, csr_wr, csr_rd} = 4'h0;
    @(negedge sys_clk_i);
    rd = csr ? csr_rdata : mm_rdata;
  endtask
  // memory-mapped address of region r, entry s
  function automatic logic [14:0] ma(input logic [2:0] r, input int s);
    return {r, 10'(s), 2'b00};
  endfunction
  // capture then read the pointer
  task automatic claim(input logic [7:0] id);
    bus(1'b1, 1'b1, 15'(`CEI_CSR_CAPTURE), 32'h0);
    bus(1'b1, 1'b0, 15'(`CEI_CSR_HANDLER), 32'h0);
    chk("pointer", rd, {VT[31:10], id, 2'b00});
  endtask
  // verdict
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard and pulse watch
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (clr_mie)
      saw_clear = 1'b1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    bus(1'b1, 1'b0, 15'(`CEI_CSR_HANDLER), 32'h0);
    chk("ptr_reset", rd, 32'h0);
    bus(1'b1, 1'b1, 15'(`CEI_CSR_VTABLE), VT);
    claim(8'h00);
    chk("irq_reset", 32'(ext_irq), 32'h0);
    // source zero has no priority entry
    bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 0), 32'hf);
    bus(1'b0, 1'b0, ma(`CEI_RGN_PRIO, 0), 32'h0);
    chk("prio_src0", rd, 32'h0);
    bus(1'b0, 1'b1, ma(`CEI_RGN_EN, 3), 32'h1);
    bus(1'b0, 1'b1, ma(`CEI_RGN_EN, 5), 32'h1);
    u_far.drive(3, 1'b1);
    u_far.drive(5, 1'b1);
    // table of priority and threshold cases
    for (int r = 0; r < 7; r++)
    begin
      bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 3), 32'(rows[r].pa));
      bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 5), 32'(rows[r].pb));
      bus(1'b1, 1'b1, 15'(`CEI_CSR_THRESH), 32'(rows[r].thr));
      bus(1'b1, 1'b1, 15'(`CEI_CSR_CURPRI), 32'(rows[r].cur));
      repeat (2) @(negedge sys_clk_i);
      chk("ext_irq", 32'(ext_irq), 32'(rows[r].irq));
      chk("meip", 32'(meip), 32'(rows[r].irq));
      chk("wake", 32'(wake), 32'(rows[r].wake));
      chk("fetch_addr", vfa, {VT[31:10], rows[r].id, 2'b00});
      claim(rows[r].id);
      bus(1'b1, 1'b0, 15'(`CEI_CSR_CLAIMPRI), 32'h0);
      chk("claim_prio", rd, 32'(rows[r].cp));
    end
    bus(1'b0, 1'b0, ma(`CEI_RGN_PEND, 0), 32'h0);
    chk("pending", rd, 32'h00000028);
    // origin clears a level source, then a disable
    bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 3), 32'h5);
    bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 5), 32'h5);
    u_far.drive(3, 1'b0);
    repeat (8) @(negedge sys_clk_i);
    claim(8'h05);
    bus(1'b0, 1'b1, ma(`CEI_RGN_EN, 5), 32'h0);
    repeat (2) @(negedge sys_clk_i);
    chk("irq_disabled", 32'(ext_irq), 32'h0);
    // falling-edge source latched until gateway clear
    bus(1'b0, 1'b1, ma(`CEI_RGN_GWCTRL, 7), 32'h3);
    u_far.drive(7, 1'b1);
    bus(1'b0, 1'b1, ma(`CEI_RGN_GWCLR, 7), 32'h0);
    bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 7), 32'h6);
    bus(1'b0, 1'b1, ma(`CEI_RGN_EN, 7), 32'h1);
    repeat (8) @(negedge sys_clk_i);
    chk("irq_idle_high", 32'(ext_irq), 32'h0);
    u_far.pulse_low(7);
    repeat (8) @(negedge sys_clk_i);
    chk("irq_edge", 32'(ext_irq), 32'h1);
    bus(1'b0, 1'b0, ma(`CEI_RGN_PEND, 0), 32'h0);
    chk("pending_edge", 32'(rd[7]), 32'h1);
    claim(8'h07);
    bus(1'b0, 1'b1, ma(`CEI_RGN_GWCLR, 7), 32'h0);
    repeat (2) @(negedge sys_clk_i);
    chk("irq_cleared", 32'(ext_irq), 32'h0);
    // top level wakes and the hart takes it
    bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 5), 32'hf);
    bus(1'b0, 1'b1, ma(`CEI_RGN_EN, 5), 32'h1);
    repeat (2) @(negedge sys_clk_i);
    chk("wake_top", 32'(wake), 32'h1);
    chk("sleep_off", 32'(sleep_x), 32'h0);
    u_far.set_enables(1'b1, 1'b0);
    @(negedge sys_clk_i);
    chk("sleep_meie_off", 32'(sleep_x), 32'h0);
    u_far.set_enables(1'b1, 1'b1);
    @(negedge sys_clk_i);
    chk("sleep_on", 32'(sleep_x), 32'h1);
    repeat (4) @(negedge sys_clk_i);
    chk("clear_pulse", 32'(saw_clear), 32'h1);
    chk("mstatus_mie", 32'(mst_mie), 32'h0);
    // reverse order reads inverted priority
    bus(1'b0, 1'b1, ma(`CEI_RGN_CFG, 0), 32'h1);
    bus(1'b0, 1'b0, ma(`CEI_RGN_PRIO, 5), 32'h0);
    chk("prio_reversed", rd, 32'h0);
    bus(1'b1, 1'b0, 15'(`CEI_CSR_THRESH), 32'h0);
    chk("thresh_reversed", rd, 32'h0000000f);
    bus(1'b0, 1'b1, ma(`CEI_RGN_PRIO, 5), 32'h1);
    chk("wake_reversed", 32'(wake), 32'h0);
    print_verdict();
  end
endmodule // cei_evaluator_tb
`default_nettype wire

// >>> testbench/cei_far_side_model.sv
// far side model: interrupt source lines and a simple hart
// assumes the bench calls its tasks; lines move after falling edges
`timescale 1ns/1ps
`default_nettype none
module cei_far_side_model
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // from the evaluator
  input wire logic ext_irq_i,
  input wire logic clear_mstatus_mie_i,
  // to the evaluator
  output logic [255:0] src_req_o,
  output logic mstatus_mie_o,
  output logic mie_meie_o,
  output logic irq_taken_o
);
  // source lines and enables idle at time zero
  initial
  begin
    src_req_o = '0;
    mstatus_mie_o <= 1'b0;
    mie_meie_o <= 1'b0;
  end
  // a source sets or removes its own request level
  task automatic drive(input int s, input logic v);
    @(negedge sys_clk_i);
    src_req_o[s] = v;
  endtask
  // low pulse held three clocks so the synchroniser cannot miss it
  task automatic pulse_low(input int s);
    drive(s, 1'b0);
    repeat (3) @(negedge sys_clk_i);
    src_req_o[s] = 1'b1;
  endtask
  // firmware view of the hart enables
  task automatic set_enables(input logic g, input logic e);
    @(negedge sys_clk_i);
    mstatus_mie_o <= g;
    mie_meie_o <= e;
  endtask
  // hart takes the interrupt once, then drops its global enable
  always @(posedge sys_clk_i or posedge reset_i)
    if (reset_i)
      irq_taken_o <= 1'b0;
    else
    begin
      irq_taken_o <= ext_irq_i && mstatus_mie_o && mie_meie_o && !irq_taken_o
        && !clear_mstatus_mie_i;
      if (clear_mstatus_mie_i)
        mstatus_mie_o <= 1'b0;
    end
endmodule // cei_far_side_model
`default_nettype wire

// >>> verilog/cei_cmp_tree.sv
// comparator tree: highest priority, lowest source id among gated entries
// assumes entry 0 carries no-priority so a silent tree yields id 0
`include "cei_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cei_cmp_tree
  import cei_pkg::*;
(
  // gated priorities, entry i at bits [4i+3:4i]
  input wire logic [256*`CEI_PRIO_W-1:0] prio_flat_i,
  // result
  output cei_pkg::cei_prio_t max_prio_o,
  output cei_pkg::cei_id_t win_id_o
);
  import cei_pkg::*;

  // two-input compare: right wins only if strictly higher
  function automatic logic [11:0] cei_pick(input logic [11:0] l, input logic [11:0] r);
    cei_pick = (r[11:8] > l[11:8]) ? r : l;
  endfunction

  logic [11:0] node [0:8][0:255]; // {prio, id} per level and slot

  genvar i, lv;
  generate
    // leaves carry hardwired ids
    for (i = 0; i < 256; i++)
    begin : g_leaf
      assign node[0][i] = {prio_flat_i[i*`CEI_PRIO_W +: `CEI_PRIO_W], 8'(i)};
    end
    // each level halves the field, lower ids on the left
    for (lv = 1; lv <= 8; lv++)
    begin : g_lvl
      for (i = 0; i < (256 >> lv); i++)
      begin : g_node
        assign node[lv][i] = cei_pick(node[lv-1][2*i], node[lv-1][2*i+1]);
      end
    end
  endgenerate

  assign max_prio_o = node[8][0][11:8];
  assign win_id_o = node[8][0][7:0];
endmodule // cei_cmp_tree
`default_nettype wire

// >>> verilog/cei_evaluator.sv
// core external interrupt evaluator: gateways, register file, tree, hart lines
// assumes word accesses on both register ports and a hart that samples the lines
`include "cei_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cei_evaluator
  import cei_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // interrupt sources, bit 0 unused
  input wire logic [`CEI_NUM_SRC:0] src_req_i,
  // memory-mapped register port
  input wire logic mm_wr_i,
  input wire logic mm_rd_i,
  input wire logic [`CEI_MM_ADDR_W-1:0] mm_addr_i,
  input wire logic [31:0] mm_wdata_i,
  output logic [31:0] mm_rdata_o,
  // register-space port
  input wire logic csr_wr_i,
  input wire logic csr_rd_i,
  input wire logic [`CEI_CSR_ADDR_W-1:0] csr_addr_i,
  input wire logic [31:0] csr_wdata_i,
  output logic [31:0] csr_rdata_o,
  // hart state
  input wire logic mstatus_mie_i,
  input wire logic mie_meie_i,
  input wire logic irq_taken_i,
  // hart lines
  output logic ext_irq_o,
  output logic mip_meip_o,
  output logic wake_notice_o,
  output logic sleep_exit_o,
  output logic clear_mstatus_mie_o,
  output logic [31:0] vector_fetch_addr_o
);
  import cei_pkg::*;

  // invert priority values in reverse order mode
  function automatic cei_prio_t ord_fix(input logic rev, input cei_prio_t v);
    ord_fix = rev ? ~v : v;
  endfunction

  // region hit on the memory-mapped port
  function automatic logic mm_hit(input logic [`CEI_MM_ADDR_W-1:0] a, input logic [2:0] rgn);
    mm_hit = (a[14:12] == rgn) && (a[1:0] == 2'b00);
  endfunction

  // configuration state
  cei_prio_t prio_reg [0:255]; // per-source priority, entry 0 unused
  logic [255:0] en_reg; // per-source enable
  logic [255:0] gw_edge_reg; // gateway type, 1 = edge
  logic [255:0] gw_low_reg; // gateway polarity, 1 = active low / falling
  logic order_rev_reg; // reverse priority order
  cei_prio_t thresh_reg; // global threshold
  cei_prio_t curpri_reg; // current handler level
  cei_base_t vt_base_reg; // vector table base
  cei_id_t claim_id_reg; // captured winner id
  cei_prio_t claim_prio_reg; // captured winner priority
  logic ext_irq_reg;
  logic wake_reg;
  logic sleep_exit_reg;
  logic clr_mie_reg;
  logic [31:0] vec_addr_reg;
  logic [31:0] mm_rdata_reg;
  logic [31:0] csr_rdata_reg;

  // decode and datapath wires
  logic [255:0] gw_req; // gateway requests, bit 0 tied low
  logic [255:0] gw_clr; // one-cycle clear strobes
  logic [256*`CEI_PRIO_W-1:0] gated_prio; // tree inputs
  cei_prio_t max_prio; // tree maximum
  cei_id_t win_id; // tree winner id
  cei_id_t mm_idx; // addressed source
  logic mm_idx_ok; // index within 0..255
  logic [31:0] mm_rd_next;
  logic [31:0] csr_rd_next;
  cei_prio_t thr_max; // higher of the two thresholds
  logic [31:0] handler_ptr; // assembled pointer

  assign mm_idx = mm_addr_i[9:2];
  assign mm_idx_ok = (mm_addr_i[11:10] == 2'b00);

  // gateways for sources 1..255
  assign gw_req[0] = 1'b0;
  genvar s;
  generate
    for (s = 1; s <= `CEI_NUM_SRC; s++)
    begin : g_gw
      cei_gateway u_gw (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .req_async_i(src_req_i[s]),
        .type_i(cei_gw_type_t'(gw_edge_reg[s])),
        .active_low_i(gw_low_reg[s]),
        .clear_i(gw_clr[s]),
        .req_o(gw_req[s])
      );
    end
  endgenerate

  // clear strobes from writes into the clear region
  always_comb
  begin
    gw_clr = '0;
    if (mm_wr_i && mm_hit(mm_addr_i, `CEI_RGN_GWCLR) && mm_idx_ok)
      gw_clr[mm_idx] = 1'b1;
  end

  // gate priority with request and enable
  always_comb
  begin
    gated_prio = '0;
    for (int k = 1; k < 256; k++)
    begin
      if (gw_req[k] && en_reg[k])
        gated_prio[k*`CEI_PRIO_W +: `CEI_PRIO_W] = prio_reg[k];
    end
  end

  // evaluation tree
  cei_cmp_tree u_tree (
    .prio_flat_i(gated_prio),
    .max_prio_o(max_prio),
    .win_id_o(win_id)
  );

  // per-source priorities, stored in normal order
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int k = 0; k < 256; k++)
        prio_reg[k] <= `CEI_RST_PRIO;
    end
    else if (mm_wr_i && mm_hit(mm_addr_i, `CEI_RGN_PRIO) && mm_idx_ok && mm_idx != 8'h00)
      prio_reg[mm_idx] <= ord_fix(order_rev_reg, mm_wdata_i[3:0]);
  end

  // per-source enables
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      en_reg <= '0;
    else if (mm_wr_i && mm_hit(mm_addr_i, `CEI_RGN_EN) && mm_idx_ok && mm_idx != 8'h00)
      en_reg[mm_idx] <= mm_wdata_i[0];
  end

  // gateway type and polarity
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gw_edge_reg <= '0;
      gw_low_reg <= '0;
    end
    else if (mm_wr_i && mm_hit(mm_addr_i, `CEI_RGN_GWCTRL) && mm_idx_ok && mm_idx != 8'h00)
    begin
      gw_edge_reg[mm_idx] <= mm_wdata_i[`CEI_GW_TYPE_BIT];
      gw_low_reg[mm_idx] <= mm_wdata_i[`CEI_GW_POL_BIT];
    end
  end

  // order select; only an exact hit on the config word
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      order_rev_reg <= 1'b0;
    else if (mm_wr_i && mm_hit(mm_addr_i, `CEI_RGN_CFG) && mm_addr_i[11:2] == 10'h000)
      order_rev_reg <= mm_wdata_i[0];
  end

  // thresholds and vector base
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      thresh_reg <= `CEI_RST_PRIO;
      curpri_reg <= `CEI_RST_PRIO;
      vt_base_reg <= `CEI_RST_BASE;
    end
    else if (csr_wr_i)
    begin
      case (csr_addr_i)
        `CEI_CSR_THRESH: thresh_reg <= ord_fix(order_rev_reg, csr_wdata_i[3:0]);
        `CEI_CSR_CURPRI: curpri_reg <= ord_fix(order_rev_reg, csr_wdata_i[3:0]);
        `CEI_CSR_VTABLE: vt_base_reg <= csr_wdata_i[31:10];
        default: ;
      endcase
    end
  end

  // capture of winner: any write to the capture word recaptures, raw result only
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      claim_id_reg <= `CEI_RST_ID;
      claim_prio_reg <= `CEI_RST_PRIO;
    end
    else if (csr_wr_i && csr_addr_i == `CEI_CSR_CAPTURE)
    begin
      claim_id_reg <= win_id;
      claim_prio_reg <= max_prio;
    end
    else if (csr_wr_i && csr_addr_i == `CEI_CSR_CLAIMPRI)
      claim_prio_reg <= ord_fix(order_rev_reg, csr_wdata_i[3:0]);
  end

  // higher of the two thresholds
  assign thr_max = (thresh_reg > curpri_reg) ? thresh_reg : curpri_reg;

  // hart request and wake flag, re-evaluated every cycle
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ext_irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      sleep_exit_reg <= 1'b0;
    end
    else
    begin
      ext_irq_reg <= (max_prio > thr_max);
      wake_reg <= (max_prio == `CEI_TOP_PRIO);
      sleep_exit_reg <= (max_prio == `CEI_TOP_PRIO) && mstatus_mie_i && mie_meie_i;
    end
  end

  // strobe asking the hart to drop its global enable on take
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      clr_mie_reg <= 1'b0;
    else
      clr_mie_reg <= irq_taken_i && ext_irq_reg;
  end

  // pointer: base, id shifted over two zero bits
  assign handler_ptr = {vt_base_reg, claim_id_reg, 2'b00};

  // live vector fetch address for hardware vectoring
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      vec_addr_reg <= `CEI_RST_WORD;
    else
      vec_addr_reg <= {vt_base_reg, win_id, 2'b00};
  end

  // memory-mapped read mux; unmapped reads return zero
  always_comb
  begin
    mm_rd_next = `CEI_RST_WORD;
    if (mm_hit(mm_addr_i, `CEI_RGN_PRIO) && mm_idx_ok && mm_idx != 8'h00)
      mm_rd_next[3:0] = ord_fix(order_rev_reg, prio_reg[mm_idx]);
    else if (mm_hit(mm_addr_i, `CEI_RGN_EN) && mm_idx_ok)
      mm_rd_next[0] = en_reg[mm_idx];
    else if (mm_hit(mm_addr_i, `CEI_RGN_GWCTRL) && mm_idx_ok)
    begin
      mm_rd_next[`CEI_GW_TYPE_BIT] = gw_edge_reg[mm_idx];
      mm_rd_next[`CEI_GW_POL_BIT] = gw_low_reg[mm_idx];
    end
    else if (mm_hit(mm_addr_i, `CEI_RGN_PEND) && mm_addr_i[11:5] == 7'h00)
      mm_rd_next = gw_req[mm_addr_i[4:2]*32 +: 32];
    else if (mm_hit(mm_addr_i, `CEI_RGN_CFG) && mm_addr_i[11:2] == 10'h000)
      mm_rd_next[0] = order_rev_reg;
  end

  // memory-mapped read data register
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      mm_rdata_reg <= `CEI_RST_WORD;
    else if (mm_rd_i)
      mm_rdata_reg <= mm_rd_next;
  end

  // register-space read mux
  always_comb
  begin
    csr_rd_next = `CEI_RST_WORD;
    case (csr_addr_i)
      `CEI_CSR_THRESH: csr_rd_next[3:0] = ord_fix(order_rev_reg, thresh_reg);
      `CEI_CSR_CURPRI: csr_rd_next[3:0] = ord_fix(order_rev_reg, curpri_reg);
      `CEI_CSR_CLAIMPRI: csr_rd_next[3:0] = ord_fix(order_rev_reg, claim_prio_reg);
      `CEI_CSR_VTABLE: csr_rd_next[31:10] = vt_base_reg;
      `CEI_CSR_HANDLER: csr_rd_next = handler_ptr;
      default: csr_rd_next = `CEI_RST_WORD;
    endcase
  end

  // register-space read data register
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      csr_rdata_reg <= `CEI_RST_WORD;
    else if (csr_rd_i)
      csr_rdata_reg <= csr_rd_next;
  end

  // outputs
  assign mm_rdata_o = mm_rdata_reg;
  assign csr_rdata_o = csr_rdata_reg;
  assign ext_irq_o = ext_irq_reg;
  assign mip_meip_o = ext_irq_reg;
  assign wake_notice_o = wake_reg;
  assign sleep_exit_o = sleep_exit_reg;
  assign clear_mstatus_mie_o = clr_mie_reg;
  assign vector_fetch_addr_o = vec_addr_reg;
endmodule // cei_evaluator
`default_nettype wire

// >>> verilog/cei_gateway.sv
// one source gateway: synchronises, filters, applies polarity and edge latching
// assumes req_async_i is asynchronous to sys_clk_i and held two clocks or more
`include "cei_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cei_gateway
  import cei_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // source side
  input wire logic req_async_i,
  // configuration
  input wire cei_pkg::cei_gw_type_t type_i,
  input wire logic active_low_i,
  input wire logic clear_i,
  // evaluator side
  output logic req_o
);
  import cei_pkg::*;

  logic sync1_reg; // first stage, read only by sync2
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg; // settled level of the pin
  logic act_prev_reg; // previous active state for edge detect
  logic edge_latched_flag_reg; // pending flag for edge sources
  logic active; // level after polarity
  logic edge_seen; // active edge this cycle

  // three-stage synchroniser
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= req_async_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // accept a change only when stages two and three agree
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      level_reg <= 1'b0;
    else if (sync2_reg == sync3_reg)
      level_reg <= sync3_reg;
  end

  // polarity select: inverted level or falling edge when active low
  assign active = level_reg ^ active_low_i;
  assign edge_seen = active & ~act_prev_reg;

  // previous active state
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      act_prev_reg <= 1'b0;
    else
      act_prev_reg <= active;
  end

  // edge pending flag: set wins over clear
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      edge_latched_flag_reg <= 1'b0;
    else if (type_i == CEI_GW_EDGE && edge_seen)
      edge_latched_flag_reg <= 1'b1;
    else if (clear_i)
      edge_latched_flag_reg <= 1'b0;
  end

  // level sources pass straight through, edge sources present the flag
  assign req_o = (type_i == CEI_GW_EDGE) ? edge_latched_flag_reg : active;
endmodule // cei_gateway
`default_nettype wire

// >>> verilog/cei_params.svh
// constants for the core external interrupt evaluator: offsets, fields, levels
// assumes inclusion by bare name from every design file that needs it
`ifndef CEI_PARAMS_SVH
`define CEI_PARAMS_SVH

// source and priority sizing
`define CEI_NUM_SRC 255
`define CEI_ID_W 8
`define CEI_PRIO_W 4
`define CEI_TOP_PRIO 4'hf
`define CEI_NO_PRIO 4'h0
`define CEI_BASE_W 22
`define CEI_TREE_LVLS 4

// memory-mapped window: region in addr[14:12], entry index in addr[9:2] with addr[11:10] zero
`define CEI_MM_ADDR_W 15
`define CEI_RGN_PRIO 3'h0
`define CEI_RGN_PEND 3'h1
`define CEI_RGN_EN 3'h2
`define CEI_RGN_CFG 3'h3
`define CEI_RGN_GWCTRL 3'h4
`define CEI_RGN_GWCLR 3'h5
`define CEI_PEND_WORDS 8

// gateway control word fields
`define CEI_GW_POL_BIT 0
`define CEI_GW_TYPE_BIT 1

// register-port window (one word per index)
`define CEI_CSR_ADDR_W 3
`define CEI_CSR_THRESH 3'h0
`define CEI_CSR_VTABLE 3'h1
`define CEI_CSR_HANDLER 3'h2
`define CEI_CSR_CAPTURE 3'h3
`define CEI_CSR_CLAIMPRI 3'h4
`define CEI_CSR_CURPRI 3'h5

// reset values
`define CEI_RST_PRIO 4'h0
`define CEI_RST_BASE 22'h000000
`define CEI_RST_ID 8'h00
`define CEI_RST_WORD 32'h00000000

`endif

// >>> verilog/cei_pkg.sv
// types shared by the core external interrupt evaluator
// assumes cei_params.svh supplies the widths
`include "cei_params.svh"
package cei_pkg;
  typedef logic [`CEI_PRIO_W-1:0] cei_prio_t;
  typedef logic [`CEI_ID_W-1:0] cei_id_t;
  typedef logic [`CEI_BASE_W-1:0] cei_base_t;
  typedef enum logic {CEI_GW_LEVEL = 1'b0, CEI_GW_EDGE = 1'b1} cei_gw_type_t;
endpackage
